// *** dcs_bbm_switch.sv ***
/*
  Break-before-make driver for the two oscillator buffer enables.
  Assumes the target selection is a level in the ref_clk domain.
*/
`timescale 1ns/1ps
module dcs_bbm_switch
  import dcs_pkg::*;
(
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // requested setting
  input  wire logic target_osc,
  input  wire logic target_mult4,
  // buffer enables, active low
  output logic      osc_a_oe_n,
  output logic      osc_b_oe_n,
  // state
  output logic      active_osc,
  output logic      active_mult4,
  output logic      gap,
  output logic      switch_done
);

  typedef enum logic [1:0] {ST_RUN, ST_BREAK} dcs_bbm_state_t;

  dcs_bbm_state_t         state_q;
  logic [BBM_CNT_W-1:0]   gap_cnt_q;
  logic                   osc_q;
  logic                   mult_q;
  logic                   en_q;
  logic                   done_q;
  logic                   moved_q;
  logic                   change;

  assign change = (target_osc != osc_q) || (target_mult4 != mult_q);

  // ************************************************************
  // sequencing
  // ************************************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= ST_BREAK;
      gap_cnt_q <= '0;
      osc_q     <= 1'b0;
      mult_q    <= 1'b0;
      en_q      <= 1'b0;
      done_q    <= 1'b0;
      moved_q   <= 1'b0;
    end else begin
      done_q <= 1'b0;
      unique case (state_q)
        ST_RUN: begin
          if (change) begin
            en_q      <= 1'b0;
            gap_cnt_q <= '0;
            state_q   <= ST_BREAK;
          end
        end
        ST_BREAK: begin
          // track the target while stopped; enable only once it held two edges,
          // so the registered straps are settled before the clock returns
          osc_q   <= target_osc;
          mult_q  <= target_mult4;
          moved_q <= change;
          if ((gap_cnt_q >= BBM_CNT_W'(BBM_GAP_CYC)) && !change && !moved_q) begin
            en_q    <= 1'b1;
            done_q  <= 1'b1;
            state_q <= ST_RUN;
          end else if (gap_cnt_q < BBM_CNT_W'(BBM_GAP_CYC)) begin
            gap_cnt_q <= gap_cnt_q + 1'b1;
          end
        end
      endcase
    end
  end

  // only the selected oscillator buffer is ever enabled
  assign osc_a_oe_n   = ~(en_q & ~osc_q);
  assign osc_b_oe_n   = ~(en_q & osc_q);
  assign active_osc   = osc_q;
  assign active_mult4 = mult_q;
  assign gap          = (state_q == ST_BREAK);
  assign switch_done  = done_q;

endmodule : dcs_bbm_switch

// *** dcs_clock_select.sv ***
/*
  Top of the processor clock source selector: register port, selection
  source, switch debounce, break-before-make control and memory clock status.
  Assumes all inputs are synchronous to ref_clk; the processor itself derives
  the burst sram and sdram clocks from its core clock.
*/
`timescale 1ns/1ps

// Notes on behaviour
// - enable only the buffer of the currently selected oscillator.
// - on a change, disable the old buffer before enabling the new.
// - selection from dip switch standalone, from software switch in host slot.
// - pll mode and frequency-range straps follow the multiply-by-1 or by-4 choice.
// - cpu clock is 33.25 or 50 MHz by 1, 133 or 200 MHz by 4.
// - burst sram clock runs at half or full cpu rate, per processor software.
// - sdram clock is always half the cpu clock.
module dcs_clock_select
  import dcs_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYC
)(
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  // register port
  input  wire logic [ADDR_W-1:0]     reg_addr,
  input  wire logic [DATA_W-1:0]     reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [DATA_W-1:0]     reg_rdata,
  // board straps and switches
  input  wire logic                  board_in_slot,
  input  wire logic                  dip_osc_sel,
  input  wire logic                  dip_mult4,
  // processor memory rate setting
  input  wire logic                  burst_sram_rate_select,
  // oscillator buffer enables, active low
  output logic                       osc_a_oe_n,
  output logic                       osc_b_oe_n,
  // processor pll straps
  output logic                       pll_multiply_select,
  output logic      [PLL_FREQ_W-1:0] pll_frequency_range
);

  // ************************************************************
  // declarations
  // ************************************************************
  logic [1:0]            ctrl_q;
  logic [1:0]            dip_last_q;
  logic [1:0]            dip_stable_q;
  logic [DEB_CNT_W-1:0]  deb_cnt_q;
  logic [1:0]            event_q;
  logic [7:0]            swcnt_q;
  logic [DATA_W-1:0]     rdata_q;
  logic [DATA_W-1:0]     rdata_d;
  logic [DATA_W-1:0]     status_word;
  logic                  sram_rate_q;
  logic                  target_osc;
  logic                  target_mult4;
  logic                  active_osc;
  logic                  active_mult4;
  logic                  gap;
  logic                  switch_done;
  logic                  rate_bad;
  logic                  sram_half;
  logic                  wr_ctrl;
  logic                  wr_event;
  logic [1:0]            dip_now;
  dcs_cpu_rate_t         cpu_rate;

  assign wr_ctrl  = reg_wr && (reg_addr == REG_CTRL);
  assign wr_event = reg_wr && (reg_addr == REG_EVENT);
  assign dip_now  = {dip_mult4, dip_osc_sel};

  // ************************************************************
  // software switch
  // ************************************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= {reg_wdata[CTRL_MULT_BIT], reg_wdata[CTRL_OSC_BIT]};
    end
  end

  // ************************************************************
  // dip switch debounce
  // ************************************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dip_last_q <= 2'h0;
      deb_cnt_q  <= '0;
    end else if (dip_now != dip_last_q) begin
      dip_last_q <= dip_now;
      deb_cnt_q  <= '0;
    end else if (deb_cnt_q != DEB_CNT_W'(DEBOUNCE_CYCLES)) begin
      deb_cnt_q <= deb_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dip_stable_q <= 2'h0;
    end else if (deb_cnt_q == DEB_CNT_W'(DEBOUNCE_CYCLES)) begin
      dip_stable_q <= dip_last_q;
    end
  end

  // ************************************************************
  // selection source
  // ************************************************************
  // host slot operation takes the software switch, standalone takes the dip
  assign target_osc   = board_in_slot ? ctrl_q[0] : dip_stable_q[0];
  assign target_mult4 = board_in_slot ? ctrl_q[1] : dip_stable_q[1];

  // ************************************************************
  // break-before-make oscillator switch
  // ************************************************************
  dcs_bbm_switch u_bbm (
    .ref_clk      (ref_clk),
    .rst_n        (rst_n),
    .target_osc   (target_osc),
    .target_mult4 (target_mult4),
    .osc_a_oe_n   (osc_a_oe_n),
    .osc_b_oe_n   (osc_b_oe_n),
    .active_osc   (active_osc),
    .active_mult4 (active_mult4),
    .gap          (gap),
    .switch_done  (switch_done)
  );

  // ************************************************************
  // pll straps
  // ************************************************************
  dcs_pll_drive u_pll (
    .ref_clk             (ref_clk),
    .rst_n               (rst_n),
    .target_osc          (target_osc),
    .target_mult4        (target_mult4),
    .gap                 (gap),
    .pll_multiply_select (pll_multiply_select),
    .pll_frequency_range (pll_frequency_range),
    .cpu_rate            (cpu_rate)
  );

  // ************************************************************
  // memory clock rate check
  // ************************************************************
  // rate select high means burst sram at full cpu rate
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sram_rate_q <= 1'b0;
    end else begin
      sram_rate_q <= burst_sram_rate_select;
    end
  end

  assign sram_half = ~sram_rate_q;
  // full rate at 200 MHz is an illegal software setting; ignored while switching
  assign rate_bad  = sram_rate_q && (cpu_rate == CPU_200M) && !gap;

  // ************************************************************
  // sticky events, set wins over clear
  // ************************************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      event_q <= EV_RST;
    end else begin
      event_q[EV_BAD_BIT] <= rate_bad ||
        (event_q[EV_BAD_BIT] && !(wr_event && reg_wdata[EV_BAD_BIT]));
      event_q[EV_SWITCH_BIT] <= switch_done ||
        (event_q[EV_SWITCH_BIT] && !(wr_event && reg_wdata[EV_SWITCH_BIT]));
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      swcnt_q <= SWCNT_RST;
    end else if (switch_done) begin
      swcnt_q <= swcnt_q + 8'h01;
    end
  end

  // ************************************************************
  // status word
  // ************************************************************
  // sdram clock is always half rate, so only the sram rate is reported
  always_comb begin
    status_word = '0;
    status_word[ST_OSC_BIT]  = active_osc;
    status_word[ST_MULT_BIT] = active_mult4;
    status_word[ST_BUSY_BIT] = gap;
    status_word[ST_SLOT_BIT] = board_in_slot;
    status_word[ST_BAD_BIT]  = rate_bad;
    status_word[ST_SRAM_BIT] = sram_half;
    status_word[ST_RATE_LSB +: 2] = cpu_rate;
    status_word[ST_DIP_LSB +: 2]  = dip_stable_q;
  end

  // ************************************************************
  // register read
  // ************************************************************
  always_comb begin
    rdata_d = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        REG_CTRL:   rdata_d = {{(DATA_W-2){1'b0}}, ctrl_q};
        REG_STATUS: rdata_d = status_word;
        REG_EVENT:  rdata_d = {{(DATA_W-2){1'b0}}, event_q};
        REG_SWCNT:  rdata_d = {{(DATA_W-8){1'b0}}, swcnt_q};
        default:    rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

endmodule : dcs_clock_select

// *** dcs_clock_select_monitor.sv ***
/*
  Port checker for the processor clock source selector.
  Assumes it is bound onto dcs_clock_select and sees only its ports.
*/
`timescale 1ns/1ps
module dcs_clock_select_chk
  import dcs_pkg::*;
(
  // clock and reset
  input wire logic                  ref_clk,
  input wire logic                  rst_n,
  // register port
  input wire logic [ADDR_W-1:0]     reg_addr,
  input wire logic [DATA_W-1:0]     reg_wdata,
  input wire logic                  reg_wr,
  input wire logic                  reg_rd,
  input wire logic [DATA_W-1:0]     reg_rdata,
  // enables and straps
  input wire logic                  osc_a_oe_n,
  input wire logic                  osc_b_oe_n,
  input wire logic                  pll_multiply_select,
  input wire logic [PLL_FREQ_W-1:0] pll_frequency_range
);
  // ************************************************************
  // checks
  // ************************************************************
  logic [3:0] off_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      off_q <= 4'h0;
    end else if (osc_a_oe_n && osc_b_oe_n) begin
      off_q <= (off_q == 4'hF) ? off_q : off_q + 4'h1;
    end else begin
      off_q <= 4'h0;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence both_off_s;
    osc_a_oe_n && osc_b_oe_n;
  endsequence
  sequence ctrl_wr_rd_s;
    reg_wr && reg_addr == REG_CTRL ##1 reg_rd && reg_addr == REG_CTRL;
  endsequence
  no_overlap_a: assert property (osc_a_oe_n || osc_b_oe_n)
    else $error("both oscillator buffers enabled");
  gap_a_a: assert property ($fell(osc_a_oe_n) |-> off_q >= 4'h3)
    else $error("buffer a enabled without break gap");
  gap_b_a: assert property ($fell(osc_b_oe_n) |-> off_q >= 4'h3)
    else $error("buffer b enabled without break gap");
  strap_hold_a: assert property ($changed(pll_multiply_select) ||
    $changed(pll_frequency_range) |-> both_off_s) else $error("straps moved with clock on");
  bypass_a: assert property (!pll_multiply_select |->
    pll_frequency_range == PLL_FREQ_BYPASS) else $error("range not bypass in by-1 mode");
  x4_low_a: assert property (pll_multiply_select && !osc_a_oe_n |->
    pll_frequency_range == PLL_FREQ_LOW) else $error("range wrong for x4 from osc a");
  x4_high_a: assert property (pll_multiply_select && !osc_b_oe_n |->
    pll_frequency_range == PLL_FREQ_HIGH) else $error("range wrong for x4 from osc b");
  ctrl_rdback_a: assert property (ctrl_wr_rd_s |=>
    reg_rdata[1:0] == 2'($past(reg_wdata, 2))) else $error("software switch readback wrong");
endmodule : dcs_clock_select_chk

bind dcs_clock_select dcs_clock_select_chk u_dcs_clock_select_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .osc_a_oe_n(osc_a_oe_n),
  .osc_b_oe_n(osc_b_oe_n), .pll_multiply_select(pll_multiply_select),
  .pll_frequency_range(pll_frequency_range));

// *** dcs_pkg.sv ***
/*
  Constants, register map and types shared by the processor clock source selector.
  Assumes a single 20 MHz reference clock and a plain strobe-based register port.
*/
package dcs_pkg;

  // ************************************************************
  // register port
  // ************************************************************
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_EVENT  = 8'h08;
  localparam logic [7:0] REG_SWCNT  = 8'h0C;

  // control register fields
  localparam int unsigned CTRL_OSC_BIT  = 0;
  localparam int unsigned CTRL_MULT_BIT = 1;
  localparam logic [1:0]  CTRL_RST      = 2'h0;

  // status register fields
  localparam int unsigned ST_OSC_BIT    = 0;
  localparam int unsigned ST_MULT_BIT   = 1;
  localparam int unsigned ST_BUSY_BIT   = 2;
  localparam int unsigned ST_SLOT_BIT   = 3;
  localparam int unsigned ST_BAD_BIT    = 4;
  localparam int unsigned ST_SRAM_BIT   = 5;
  localparam int unsigned ST_RATE_LSB   = 8;
  localparam int unsigned ST_DIP_LSB    = 12;

  // event register fields, write one to clear
  localparam int unsigned EV_BAD_BIT    = 0;
  localparam int unsigned EV_SWITCH_BIT = 1;
  localparam logic [1:0]  EV_RST        = 2'h0;
  localparam logic [7:0]  SWCNT_RST     = 8'h00;

  // ************************************************************
  // processor pll strap encodings
  // ************************************************************
  localparam int unsigned PLL_FREQ_W     = 2;
  localparam logic [1:0]  PLL_FREQ_BYPASS = 2'h0;
  localparam logic [1:0]  PLL_FREQ_LOW    = 2'h1;
  localparam logic [1:0]  PLL_FREQ_HIGH   = 2'h2;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned BBM_GAP_NS    = 100;
  localparam int unsigned BBM_GAP_CYC   =
    (BBM_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BBM_CNT_W     = 4;
  localparam int unsigned DEBOUNCE_NS   = 1000000;
  localparam int unsigned DEBOUNCE_CYC  =
    (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DEB_CNT_W     = 16;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {
    CPU_33M25,
    CPU_50M,
    CPU_133M,
    CPU_200M
  } dcs_cpu_rate_t;

endpackage : dcs_pkg

// *** dcs_pll_drive.sv ***
/*
  Drives the processor pll mode and frequency range straps and the rate code.
  Assumes straps may only move while the input clock is stopped.
*/
`timescale 1ns/1ps
module dcs_pll_drive
  import dcs_pkg::*;
(
  // clock and reset
  input  wire logic            ref_clk,
  input  wire logic            rst_n,
  // setting and gap window
  input  wire logic            target_osc,
  input  wire logic            target_mult4,
  input  wire logic            gap,
  // processor straps and cpu rate code
  output logic                 pll_multiply_select,
  output logic [PLL_FREQ_W-1:0] pll_frequency_range,
  output dcs_cpu_rate_t        cpu_rate
);

  logic osc_q;
  logic mult_q;

  // ************************************************************
  // latch while the clock is stopped
  // ************************************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_q  <= 1'b0;
      mult_q <= 1'b0;
    end else if (gap) begin
      osc_q  <= target_osc;
      mult_q <= target_mult4;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pll_multiply_select <= 1'b0;
      pll_frequency_range <= PLL_FREQ_BYPASS;
    end else begin
      pll_multiply_select <= mult_q;
      if (!mult_q)
        pll_frequency_range <= PLL_FREQ_BYPASS;
      else if (osc_q)
        pll_frequency_range <= PLL_FREQ_HIGH;
      else
        pll_frequency_range <= PLL_FREQ_LOW;
    end
  end

  // cpu core clock follows oscillator and multiplier
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_rate <= CPU_33M25;
    end else begin
      unique case ({mult_q, osc_q})
        2'h0: cpu_rate <= CPU_33M25;
        2'h1: cpu_rate <= CPU_50M;
        2'h2: cpu_rate <= CPU_133M;
        2'h3: cpu_rate <= CPU_200M;
      endcase
    end
  end

endmodule : dcs_pll_drive

// *** dcs_proc_model.sv ***
/*
  Behavioural model of the two oscillators and the processor clock inputs.
  Assumes osc a is 33.25 MHz and osc b 50 MHz; rates given in kHz.
*/
`timescale 1ns/1ps
module dcs_proc_model
  import dcs_pkg::*;
(
  // enables and straps from the selector
  input  wire logic                  osc_a_oe_n,
  input  wire logic                  osc_b_oe_n,
  input  wire logic                  pll_multiply_select,
  input  wire logic [PLL_FREQ_W-1:0] pll_frequency_range,
  // software wish for full-rate sram clock
  input  wire logic                  sram_full_req,
  // processor side
  output logic                       burst_sram_rate_select,
  output logic                       clash,
  output logic      [31:0]           cpu_khz,
  output logic      [31:0]           sram_khz,
  output logic      [31:0]           sdram_khz
);
  // ************************************************************
  // clock tree
  // ************************************************************
  logic [31:0] in_khz;
  always_comb begin
    clash = !osc_a_oe_n && !osc_b_oe_n;
    in_khz = !osc_a_oe_n ? 32'h81E2 : (!osc_b_oe_n ? 32'hC350 : 32'h0);
    cpu_khz = !pll_multiply_select ? in_khz :
      ((pll_frequency_range == PLL_FREQ_BYPASS) ? 32'h0 : in_khz << 2);
    burst_sram_rate_select = sram_full_req &&
      !(pll_multiply_select && (pll_frequency_range == PLL_FREQ_HIGH));
    sram_khz = burst_sram_rate_select ? cpu_khz : cpu_khz >> 1;
    sdram_khz = cpu_khz >> 1;
  end
endmodule : dcs_proc_model

// *** test_dcs_clock_select.sv ***
/*
  Self-checking bench for the processor clock source selector.
  Assumes dcs_proc_model stands at the processor side.
*/
`timescale 1ns/1ps
module test_dcs_clock_select
  import dcs_pkg::*;
;
  // ************************************************************
  // bench
  // ************************************************************
  localparam int DEB = 8;
  logic                  ref_clk, rst_n, reg_wr, reg_rd, board_in_slot, dip_osc_sel;
  logic                  dip_mult4, rate_sel, osc_a_oe_n, osc_b_oe_n, pll_mul, clash;
  logic [ADDR_W-1:0]     reg_addr;
  logic [DATA_W-1:0]     reg_wdata, reg_rdata;
  logic [PLL_FREQ_W-1:0] pll_rng;
  logic [31:0]           cpu_khz, sram_khz, sdram_khz;
  int                    miscompares, total_checks;

  dcs_clock_select #(.DEBOUNCE_CYCLES(DEB)) u_dcs_clock_select (.ref_clk(ref_clk),
    .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .board_in_slot(board_in_slot),
    .dip_osc_sel(dip_osc_sel), .dip_mult4(dip_mult4), .burst_sram_rate_select(rate_sel),
    .osc_a_oe_n(osc_a_oe_n), .osc_b_oe_n(osc_b_oe_n), .pll_multiply_select(pll_mul),
    .pll_frequency_range(pll_rng));
  dcs_proc_model u_dcs_proc_model (.osc_a_oe_n(osc_a_oe_n), .osc_b_oe_n(osc_b_oe_n),
    .pll_multiply_select(pll_mul), .pll_frequency_range(pll_rng), .sram_full_req(1'b1),
    .burst_sram_rate_select(rate_sel), .clash(clash), .cpu_khz(cpu_khz),
    .sram_khz(sram_khz), .sdram_khz(sdram_khz));

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic settle();
    int n;
    n = 0;
    while (!(osc_a_oe_n && osc_b_oe_n) && n < 40) begin
      @(posedge ref_clk);
      #1 n++;
    end
    chk("break gap", {31'h0, osc_a_oe_n & osc_b_oe_n}, 32'h1);
    n = 0;
    while (osc_a_oe_n && osc_b_oe_n && n < 40) begin
      @(posedge ref_clk);
      #1 n++;
    end
  endtask : settle
  task automatic chk_state(input logic osc, input logic mult);
    logic [31:0] s, cpu;
    cpu = osc ? 32'hC350 : 32'h81E2;
    cpu = mult ? cpu << 2 : cpu;
    chk("enable a", {31'h0, osc_a_oe_n}, {31'h0, osc});
    chk("enable b", {31'h0, osc_b_oe_n}, {31'h0, !osc});
    chk("pll mode", {31'h0, pll_mul}, {31'h0, mult});
    chk("pll range", {30'h0, pll_rng}, mult ? (osc ? 32'h2 : 32'h1) : 32'h0);
    chk("cpu clock", cpu_khz, cpu);
    chk("sdram clock", sdram_khz, cpu >> 1);
    chk("sram clock", sram_khz, (cpu == 32'h30D40) ? cpu >> 1 : cpu);
    chk("no clash", {31'h0, clash}, 32'h0);
    rd(REG_STATUS, s);
    chk("status active", {30'h0, s[1:0]}, {30'h0, mult, osc});
    chk("status rate", {30'h0, s[9:8]}, {30'h0, mult, osc});
    chk("status half", {31'h0, s[5]}, {31'h0, cpu == 32'h30D40});
  endtask : chk_state
  task automatic t_reset();
    chk("reset enables", {30'h0, osc_a_oe_n, osc_b_oe_n}, 32'h3);
    chk("reset straps", {29'h0, pll_mul, pll_rng}, 32'h0);
    rst_n <= 1'b1;
    settle();
    chk_state(1'b0, 1'b0);
  endtask : t_reset
  task automatic t_dip();
    dip_osc_sel <= 1'b1;
    dip_mult4 <= 1'b1;
    settle();
    chk_state(1'b1, 1'b1);
  endtask : t_dip
  task automatic t_slot();
    logic [1:0] seq [4] = '{2'h1, 2'h2, 2'h0, 2'h3};
    logic [31:0] d;
    wr(REG_CTRL, 32'h3);
    board_in_slot <= 1'b1;
    @(posedge ref_clk);
    foreach (seq[i]) begin
      wr(REG_CTRL, {30'h0, seq[i]});
      rd(REG_CTRL, d);
      chk("ctrl readback", d, {30'h0, seq[i]});
      settle();
      chk_state(seq[i][0], seq[i][1]);
    end
    dip_osc_sel <= 1'b0;
    repeat (DEB + 6) @(posedge ref_clk);
    chk("dip ignored in slot", {31'h0, osc_b_oe_n}, 32'h0);
    rd(8'h10, d);
    chk("unmapped read", d, 32'h0);
    rd(REG_SWCNT, d);
    chk("switch count", d, 32'h6);
    rd(REG_EVENT, d);
    chk("events", d, 32'h2);
    wr(REG_EVENT, 32'h3);
    rd(REG_EVENT, d);
    chk("events cleared", d, 32'h0);
  endtask : t_slot
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    miscompares++;
    wrap_up();
  end
  initial begin
    {rst_n, reg_wr, reg_rd, board_in_slot, dip_osc_sel, dip_mult4} = 6'h0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    repeat (6) @(posedge ref_clk);
    t_reset();
    t_dip();
    t_slot();
    wrap_up();
  end
endmodule : test_dcs_clock_select
